// [logic/adcctl_defines.vh]
// Operation
// R1: Lead codes 0-3 fire code+1 core clocks early
// R2: Resolution field picks 12, 10, 8, 6 bits
// R3: Core period is twice divider, minimum two
// R4: Level-sensitive trigger keeps converting while asserted
// R5: Edge-sensitive trigger converts once per rising edge
// R6: Twenty-one sensitivity bits across low and high registers
// R7: High sensitivity register upper bits read zero
// R8: Enable bit gates each channel's early interrupt
// R9: Sensitivity and enable bits read/write, reset zero
// R10: Enables for inputs 16-20 in high register
// R11: Flag sets on early interrupt, clears on read
// R12: Lead codes 4-7 fire five to eight early
// R13: Software avoids leads longer than the conversion
// R14: Divider even duty, reloads at period boundary
`ifndef ADCCTL_DEFINES_VH
`define ADCCTL_DEFINES_VH

// ****************************************************************
// Register word indices
// ****************************************************************
`define ADCCTL_IDX_CORE_CTL_HIGH 3'h0
`define ADCCTL_IDX_LVL_LOW 3'h1
`define ADCCTL_IDX_LVL_HIGH 3'h2
`define ADCCTL_IDX_EIE_LOW 3'h3
`define ADCCTL_IDX_EIE_HIGH 3'h4
`define ADCCTL_IDX_FLAG_LOW 3'h5
`define ADCCTL_IDX_FLAG_HIGH 3'h6
`define ADCCTL_IDX_STATUS 3'h7

// ****************************************************************
// Field positions of the core control register
// ****************************************************************
`define ADCCTL_LEAD_MSB 12
`define ADCCTL_LEAD_LSB 10
`define ADCCTL_RES_MSB 9
`define ADCCTL_RES_LSB 8
`define ADCCTL_DIV_MSB 6
`define ADCCTL_DIV_LSB 0

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define ADCCTL_CORE_CTL_RESET 16'h0000
`define ADCCTL_CHAN_RESET 21'h000000
`define ADCCTL_NCHAN 21
`define ADCCTL_HIGH_BITS 5

// ****************************************************************
// Resolution codes and conversion timing in core clocks
// ****************************************************************
`define ADCCTL_RES_12 2'h3
`define ADCCTL_RES_10 2'h2
`define ADCCTL_RES_8 2'h1
`define ADCCTL_RES_6 2'h0
`define ADCCTL_CONV_OVERHEAD 4'h2

`endif

// [logic/adcctl_clkdiv.v]
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Core clock divider
// ****************************************************************
module adcctl_clkdiv (
    input wire mclk_in,
    input wire rst_in,
    input wire [6:0] div_in,
    output reg core_clk_out,
    output reg core_tick_out
);

    reg [6:0] half_reg; // Active half period in source clocks
    reg [6:0] cnt_reg; // Source clocks within current half
    wire [6:0] div_eff; // Zero behaves as one

    assign div_eff = (div_in == 7'h00) ? 7'h01 : div_in; // see R3

    // Count half periods, toggle the clock, reload at period end
    always @(posedge mclk_in) begin
        if (rst_in) begin
            half_reg <= 7'h01;
            cnt_reg <= 7'h00;
            core_clk_out <= 1'b0;
            core_tick_out <= 1'b0;
        end else begin
            core_tick_out <= 1'b0;
            if (cnt_reg + 7'h01 >= half_reg) begin
                cnt_reg <= 7'h00;
                core_clk_out <= ~core_clk_out; // Equal halves, see R14
                if (core_clk_out) begin
                    // Falling edge closes a period: tick and reload
                    core_tick_out <= 1'b1;
                    half_reg <= div_eff; // see R14
                end
            end else begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end

endmodule

`default_nettype wire

// [logic/adcctl_core.v]
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "adcctl_defines.vh"

// ****************************************************************
// Converter core timing and trigger control
// ****************************************************************
module adcctl_core (
    input wire mclk_in,
    input wire rst_in,
    input wire [2:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    input wire [20:0] trig_in,
    input wire [20:0] buf_read_in,
    output wire core_clk_out,
    output reg early_irq_out,
    output reg [4:0] early_irq_chan_out,
    output reg result_ready_out,
    output reg [4:0] ready_chan_out,
    output reg busy_out
);

    // ****************************************************************
    // Decoding functions
    // ****************************************************************

    // Lowest numbered requesting channel
    function [4:0] first_chan;
        input [20:0] req;
        integer k;
        begin
            first_chan = 5'h00;
            for (k = 20; k >= 0; k = k - 1) begin
                if (req[k]) begin
                    first_chan = k[4:0];
                end
            end
        end
    endfunction

    // Conversion length in core clocks from the resolution code
    function [3:0] conv_len;
        input [1:0] res;
        begin
            case (res) // see R2
                `ADCCTL_RES_12: conv_len = 4'hc + `ADCCTL_CONV_OVERHEAD;
                `ADCCTL_RES_10: conv_len = 4'ha + `ADCCTL_CONV_OVERHEAD;
                `ADCCTL_RES_8: conv_len = 4'h8 + `ADCCTL_CONV_OVERHEAD;
                default: conv_len = 4'h6 + `ADCCTL_CONV_OVERHEAD;
            endcase
        end
    endfunction

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    localparam ST_IDLE = 1'b0; // Waiting for a trigger
    localparam ST_CONV = 1'b1; // Conversion running

    reg [15:0] core_ctl_reg; // Lead select, resolution, divider
    reg [20:0] lvl_reg; // Per-input level sensitivity
    reg [20:0] eie_reg; // Per-input early interrupt enable
    reg [20:0] flag_reg; // Per-input early interrupt flag
    reg [20:0] flag_next;
    reg [20:0] trig_d_reg; // Trigger of previous cycle
    reg [20:0] pend_reg; // Latched edge requests
    reg state_reg;
    reg [3:0] remain_reg; // Core clocks to result ready
    reg [4:0] chan_reg; // Channel being converted

    wire core_tick; // One cycle per core clock period
    wire [2:0] lead_sel;
    wire [3:0] lead_cnt; // Core clocks of lead
    wire [20:0] req; // Channels asking for a conversion
    wire [20:0] edge_hit; // Rising edges on triggers
    wire start; // Conversion begins this cycle
    wire early_now; // Early point reached this cycle
    wire [4:0] start_chan;
    wire [3:0] start_len;

    assign lead_sel = core_ctl_reg[`ADCCTL_LEAD_MSB:`ADCCTL_LEAD_LSB];
    assign lead_cnt = {1'b0, lead_sel} + 4'h1; // see R1 see R12
    assign start = core_tick && (state_reg == ST_IDLE) && (req != 21'h000000);
    assign start_chan = first_chan(req);
    assign start_len = conv_len(core_ctl_reg[`ADCCTL_RES_MSB:`ADCCTL_RES_LSB]);

    // ****************************************************************
    // Core clock divider
    // ****************************************************************
    adcctl_clkdiv u_div (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .div_in(core_ctl_reg[`ADCCTL_DIV_MSB:`ADCCTL_DIV_LSB]),
        .core_clk_out(core_clk_out),
        .core_tick_out(core_tick)
    );

    // ****************************************************************
    // Trigger sensitivity per channel
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `ADCCTL_NCHAN; g = g + 1) begin : g_trig
            // Edge detect on the synchronous trigger input
            assign edge_hit[g] = trig_in[g] & ~trig_d_reg[g];
            // Level mode asks while high, edge mode asks once
            assign req[g] = lvl_reg[g] ? trig_in[g] : pend_reg[g]; // see R4 see R5
        end
    endgenerate

    // Latch edges until the conversion of that channel starts
    always @(posedge mclk_in) begin
        if (rst_in) begin
            trig_d_reg <= `ADCCTL_CHAN_RESET;
            pend_reg <= `ADCCTL_CHAN_RESET;
        end else begin
            trig_d_reg <= trig_in;
            pend_reg <= (pend_reg | edge_hit) &
                ~(start ? (21'h000001 << start_chan) : 21'h000000) &
                ~lvl_reg; // see R5
        end
    end

    // ****************************************************************
    // Conversion sequencer in core clock steps
    // ****************************************************************
    // Early point: reached while counting, or at once if lead covers it
    assign early_now = core_tick && (
        (state_reg == ST_IDLE && start && start_len <= lead_cnt) ||
        (state_reg == ST_CONV && remain_reg == lead_cnt + 4'h1)); // see R1 see R12

    always @(posedge mclk_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            remain_reg <= 4'h0;
            chan_reg <= 5'h00;
            early_irq_out <= 1'b0;
            early_irq_chan_out <= 5'h00;
            result_ready_out <= 1'b0;
            ready_chan_out <= 5'h00;
            busy_out <= 1'b0;
        end else begin
            early_irq_out <= 1'b0;
            result_ready_out <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_CONV;
                        remain_reg <= start_len;
                        chan_reg <= start_chan;
                        busy_out <= 1'b1;
                        if (early_now && eie_reg[start_chan]) begin
                            early_irq_out <= 1'b1; // see R8
                            early_irq_chan_out <= start_chan;
                        end
                    end
                end
                ST_CONV: begin
                    if (core_tick) begin
                        remain_reg <= remain_reg - 4'h1;
                        if (early_now && eie_reg[chan_reg]) begin
                            early_irq_out <= 1'b1; // see R8
                            early_irq_chan_out <= chan_reg;
                        end
                        if (remain_reg == 4'h1) begin
                            // Result ready: hand the channel back
                            state_reg <= ST_IDLE;
                            busy_out <= 1'b0;
                            result_ready_out <= 1'b1;
                            ready_chan_out <= chan_reg;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Early interrupt flags
    // ****************************************************************
    // Buffer read clears, software write loads, a new event wins
    always @* begin
        flag_next = flag_reg & ~buf_read_in; // see R11
        if (wr_in && addr_in == `ADCCTL_IDX_FLAG_LOW) begin
            flag_next[15:0] = wdata_in;
        end
        if (wr_in && addr_in == `ADCCTL_IDX_FLAG_HIGH) begin
            flag_next[20:16] = wdata_in[`ADCCTL_HIGH_BITS-1:0];
        end
        if (early_now && eie_reg[start ? start_chan : chan_reg]) begin
            flag_next = flag_next |
                (21'h000001 << (start ? start_chan : chan_reg)); // see R11
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always @(posedge mclk_in) begin
        if (rst_in) begin
            core_ctl_reg <= `ADCCTL_CORE_CTL_RESET;
            lvl_reg <= `ADCCTL_CHAN_RESET; // see R9
            eie_reg <= `ADCCTL_CHAN_RESET; // see R9
            flag_reg <= `ADCCTL_CHAN_RESET;
        end else begin
            flag_reg <= flag_next;
            if (wr_in) begin
                case (addr_in)
                    `ADCCTL_IDX_CORE_CTL_HIGH: begin
                        core_ctl_reg <= wdata_in & 16'h1f7f; // Gaps stay zero
                    end
                    `ADCCTL_IDX_LVL_LOW: begin
                        lvl_reg[15:0] <= wdata_in; // see R6
                    end
                    `ADCCTL_IDX_LVL_HIGH: begin
                        lvl_reg[20:16] <= wdata_in[4:0]; // see R6
                    end
                    `ADCCTL_IDX_EIE_LOW: begin
                        eie_reg[15:0] <= wdata_in;
                    end
                    `ADCCTL_IDX_EIE_HIGH: begin
                        eie_reg[20:16] <= wdata_in[4:0]; // see R10
                    end
                    default: begin
                        core_ctl_reg <= core_ctl_reg;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Register reads, data in the following cycle
    // ****************************************************************
    always @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                `ADCCTL_IDX_CORE_CTL_HIGH: rdata_out <= core_ctl_reg;
                `ADCCTL_IDX_LVL_LOW: rdata_out <= lvl_reg[15:0];
                `ADCCTL_IDX_LVL_HIGH: rdata_out <= {11'h000, lvl_reg[20:16]}; // see R7
                `ADCCTL_IDX_EIE_LOW: rdata_out <= eie_reg[15:0];
                `ADCCTL_IDX_EIE_HIGH: rdata_out <= {11'h000, eie_reg[20:16]}; // see R10
                `ADCCTL_IDX_FLAG_LOW: rdata_out <= flag_reg[15:0];
                `ADCCTL_IDX_FLAG_HIGH: rdata_out <= {11'h000, flag_reg[20:16]};
                default: rdata_out <= {10'h000, busy_out, chan_reg}; // Status word
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

// [bench/adcctl_asserts.sv]
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Port checker for the timing and trigger control block
// ****************************************************************
module adcctl_asserts (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [2:0] addr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic early_irq_out,
    input wire logic [4:0] early_irq_chan_out,
    input wire logic result_ready_out,
    input wire logic [4:0] ready_chan_out,
    input wire logic busy_out
);
    // Longest lead: eight core periods of 254 source clocks
    localparam int LEAD_MAX = 2032;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // Source clocks since the last early interrupt, zero when none waits
    logic [11:0] wait_cnt;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wait_cnt <= 12'h000;
        end else if (early_irq_out) begin
            wait_cnt <= 12'h001;
        end else if (result_ready_out) begin
            wait_cnt <= 12'h000;
        end else if (wait_cnt != 12'h000 && wait_cnt != 12'hfff) begin
            wait_cnt <= wait_cnt + 12'h001;
        end
    end

    // Early interrupt, then the result of the same channel
    sequence s_early;
        early_irq_out;
    endsequence
    sequence s_done_same;
        result_ready_out && (ready_chan_out == early_irq_chan_out);
    endsequence

    // Unused bits of the high words after a read of them
    property p_high_zero;
        $past(rd_in) && ($past(addr_in) inside {3'h2, 3'h4, 3'h6}) |-> rdata_out[15:5] == 11'h000;
    endproperty

    // Gaps of the core control word after a read of it
    property p_ctl_zero;
        $past(rd_in) && $past(addr_in) == 3'h0 |-> rdata_out[15:13] == 3'h0 && !rdata_out[7];
    endproperty

    a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data not zero outside a read");
    a_high_unused_zero: assert property (p_high_zero)
        else $error("unused high bits read nonzero");
    a_ctl_unused_zero: assert property (p_ctl_zero)
        else $error("unused control bits read nonzero");
    a_irq_one_pulse: assert property (s_early |=> !early_irq_out)
        else $error("early interrupt longer than one cycle");
    a_ready_one_pulse: assert property (result_ready_out |=> !result_ready_out)
        else $error("result ready longer than one cycle");
    a_busy_ends_ready: assert property ($fell(busy_out) |-> result_ready_out)
        else $error("busy fell without a result");
    a_irq_in_conv: assert property (early_irq_out |-> busy_out)
        else $error("early interrupt outside a conversion");
    a_early_then_ready: assert property (wait_cnt <= LEAD_MAX)
        else $error("no result for the early channel");
    a_ready_same_chan: assert property (|wait_cnt && result_ready_out |-> s_done_same)
        else $error("result channel differs from early channel");
    a_busy_min_len: assert property ($rose(busy_out) |-> busy_out [*8])
        else $error("conversion shorter than minimum");
endmodule

bind adcctl_core adcctl_asserts u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
    .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out), .early_irq_out(early_irq_out),
    .early_irq_chan_out(early_irq_chan_out), .result_ready_out(result_ready_out),
    .ready_chan_out(ready_chan_out), .busy_out(busy_out));

`default_nettype wire

// [bench/adc_core_timing_trigger_ctl_test.sv]
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Self-checking bench for the timing and trigger control block
// ****************************************************************
module adc_core_timing_trigger_ctl_test;
    logic mclk_in, rst_in, wr_in, rd_in; // Clock, reset, strobes
    logic [2:0] addr_in; // Word index
    logic [15:0] wdata_in, rdata_out; // Bus data
    logic [20:0] trig_in, buf_read_in; // Per-channel inputs
    logic core_clk_out, early_irq_out, result_ready_out, busy_out;
    logic [4:0] early_irq_chan_out, ready_chan_out;
    int n_fail, check_count, cyc, seed, i, r, c, n;
    logic [15:0] v, d;

    adcctl_core u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .trig_in(trig_in), .buf_read_in(buf_read_in), .core_clk_out(core_clk_out),
        .early_irq_out(early_irq_out), .early_irq_chan_out(early_irq_chan_out),
        .result_ready_out(result_ready_out), .ready_chan_out(ready_chan_out),
        .busy_out(busy_out));

    // Source clock, 100 ns period
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    // Hang guard: counts a mismatch and closes the run
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            wrap_up;
        end
    end

    // Compare one value, count it, report a mismatch
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Print the counts and the verdict
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One-cycle write
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] w);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= w;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    // One-cycle read; data taken in the following cycle
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] q);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        @(negedge mclk_in);
        q = rdata_out;
    endtask

    // Writable bits of each word
    function automatic logic [15:0] rmask(input int idx);
        case (idx)
            0: rmask = 16'h1f7f;
            2, 4, 6: rmask = 16'h001f;
            7: rmask = 16'h0000;
            default: rmask = 16'hffff;
        endcase
    endfunction

    // Measure high and low time of the core clock, second period counts
    task automatic clk_check(input int dv);
        int h, l, k;
        wr_reg(3'h0, 16'(dv));
        repeat (2) begin
            k = 0;
            while (core_clk_out !== 1'b0 && k < 600) begin @(negedge mclk_in); k++; end
            k = 0;
            while (core_clk_out !== 1'b1 && k < 600) begin @(negedge mclk_in); k++; end
            h = 0;
            while (core_clk_out === 1'b1 && h < 600) begin @(negedge mclk_in); h++; end
            l = 0;
            while (core_clk_out === 1'b0 && l < 600) begin @(negedge mclk_in); l++; end
        end
        chk(h, dv < 2 ? 1 : dv, "core clock high");
        chk(l, dv < 2 ? 1 : dv, "core clock low");
    endtask

    // One edge-triggered conversion with timing, channel and flag checks
    task automatic conv(input int ch, input int code, input int res, input int dv, input int en);
        int t, te, tr, tb, p, len, lead;
        p = 2 * (dv < 2 ? 1 : dv);
        len = 8 + 2 * res;
        lead = (code + 1 < len) ? code + 1 : len;
        wr_reg(3'h0, {3'h0, code[2:0], res[1:0], 1'b0, dv[6:0]});
        wr_reg(3'h3, (en != 0 && ch < 16) ? 16'(1 << ch) : 16'h0000);
        wr_reg(3'h4, (en != 0 && ch > 15) ? 16'(1 << (ch - 16)) : 16'h0000);
        @(posedge mclk_in);
        trig_in <= 21'h1 << ch;
        @(posedge mclk_in);
        trig_in <= 21'h0;
        te = -1;
        tr = -1;
        tb = -1;
        for (t = 0; t < 3000 && tr < 0; t++) begin
            @(negedge mclk_in);
            if (busy_out === 1'b1 && tb < 0) tb = t;
            if (early_irq_out === 1'b1) te = t;
            if (result_ready_out === 1'b1) tr = t;
        end
        chk(tr - tb, len * p, "conversion length");
        chk(en != 0 ? tr - te : te, en != 0 ? lead * p : -1, "early lead");
        chk(ready_chan_out, ch, "result channel");
        if (en != 0) chk(early_irq_chan_out, ch, "early channel");
        rd_reg(ch < 16 ? 3'h5 : 3'h6, d);
        chk(d[ch % 16], en, "flag after conversion");
        @(posedge mclk_in);
        buf_read_in <= 21'h1 << ch;
        @(posedge mclk_in);
        buf_read_in <= 21'h0;
        rd_reg(ch < 16 ? 3'h5 : 3'h6, d);
        chk(d[ch % 16], 0, "flag after buffer read");
    endtask

    // Count result pulses over a window
    task automatic count_ready(input int n_cyc, output int cnt);
        cnt = 0;
        repeat (n_cyc) begin
            @(negedge mclk_in);
            if (result_ready_out === 1'b1) cnt++;
        end
    endtask

    // Main sequence
    initial begin
        seed = 55498;
        n_fail = 0;
        check_count = 0;
        cyc = 0;
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 3'h0;
        wdata_in = 16'h0000;
        trig_in = 21'h0;
        buf_read_in = 21'h0;
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (i = 0; i < 8; i++) begin
            rd_reg(i[2:0], d);
            chk(d, 16'h0000, "reset value");
        end
        for (i = 0; i < 8; i++) begin
            v = 16'($random(seed));
            wr_reg(i[2:0], v);
            rd_reg(i[2:0], d);
            chk(d, v & rmask(i), "readback");
        end
        for (i = 0; i < 7; i++) wr_reg(i[2:0], 16'h0000);
        $display("test registers done");
        clk_check(0);
        clk_check(1);
        clk_check(2);
        clk_check(127);
        $display("test divider done");
        for (r = 0; r < 4; r++) begin
            for (c = 0; c < 8; c++) begin
                if (!(r == 0 && c > 3)) conv({$random(seed)} % 21, c, r, {$random(seed)} % 4, 1);
            end
        end
        conv(20, 3, 1, 2, 0);
        $display("test conversions done");
        wr_reg(3'h0, 16'h0001);
        wr_reg(3'h2, 16'h0002);
        @(posedge mclk_in);
        trig_in <= 21'h1 << 17;
        count_ready(80, n);
        chk(n >= 3, 1, "level trigger repeats");
        chk(ready_chan_out, 17, "level channel");
        @(posedge mclk_in);
        trig_in <= 21'h0;
        repeat (40) @(posedge mclk_in);
        wr_reg(3'h2, 16'h0000);
        @(posedge mclk_in);
        trig_in <= 21'h1 << 17;
        count_ready(80, n);
        chk(n, 1, "edge trigger once");
        @(posedge mclk_in);
        trig_in <= 21'h0;
        $display("test trigger modes done");
        wrap_up;
    end
endmodule

`default_nettype wire
